// File: shared/nv_access_pkg.sv
// Constants shared by the byte storage controller and its array.
// Assumes a 100 MHz processor clock and a separate calibrated timing tick input.
package nv_access_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NV_BYTES      = 512;
  localparam int unsigned NV_ADDR_W     = 9;
  localparam logic [7:0]  ERASED_VALUE  = 8'hff;
  localparam logic [7:0]  VALUE_RESET   = 8'h00;

  // ****************************************************************
  // Control field encodings
  // ****************************************************************
  localparam logic [1:0] ACT_ATOMIC     = 2'h0;
  localparam logic [1:0] ACT_ERASE      = 2'h1;
  localparam logic [1:0] ACT_WRITE      = 2'h2;
  localparam logic [1:0] ACT_RESERVED   = 2'h3;

  // ****************************************************************
  // Timing: stall cycles and arming window in processor clocks
  // ****************************************************************
  localparam logic [2:0] READ_STALL_CYC = 3'h4;
  localparam logic [2:0] PROG_STALL_CYC = 3'h2;
  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;

  // Program times in microseconds; ticks from the calibrated oscillator
  localparam int unsigned ATOMIC_TIME_US = 3400;
  localparam int unsigned SPLIT_TIME_US  = 1800;
  localparam int unsigned TICK_PERIOD_US = 1;
  localparam int unsigned ATOMIC_TICKS   = ATOMIC_TIME_US / TICK_PERIOD_US;
  localparam int unsigned SPLIT_TICKS    = SPLIT_TIME_US / TICK_PERIOD_US;
  localparam int unsigned TICK_CNT_W     = 12;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_WRITE = 3'b100
  } prog_state_type;
endpackage : nv_access_pkg

// File: hw/nv_byte_array.sv
// Byte storage array with registered read data and per-byte erase/write.
// Assumes the controller never reads and programs in the same cycle.
`timescale 1ns/1ps
module nv_byte_array
  import nv_access_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic [NV_ADDR_W-1:0] addr_i,
  input  wire logic                 rd_i,
  input  wire logic                 erase_i,
  input  wire logic                 write_i,
  input  wire logic [7:0]           wdata_i,
  output logic      [7:0]           rdata_o
);
  logic [7:0] mem_q [NV_BYTES];

  // Write-only clears bits (AND), as in a real cell; unerased targets lose data
  always_ff @(posedge clk_i) begin
    if (erase_i) begin
      mem_q[addr_i] <= ERASED_VALUE;
    end else if (write_i) begin
      mem_q[addr_i] <= mem_q[addr_i] & wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rd_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end
endmodule : nv_byte_array

// File: hw/nv_access_ctrl.sv
// Byte-wide nonvolatile data storage controller with pointer, value and control.
// Assumes the processor writes fields through the *_we_i strobes on clk_i and
// honours stall_o; prog_tick_i is a pulse from the calibrated oscillator domain.
`timescale 1ns/1ps
// Behaviour
// - 512-byte array, single-byte read and write
// - Read stalls the processor four cycles
// - Program start stalls the processor two cycles
// - Select zero, armed strobe: erase plus write
// - Strobe stays one until programming ends
// - No other array access while programming
// - Select 01: erase only, strobe held
// - Select 10: write only, strobe held
// - Program time from calibrated oscillator ticks
// - 3.4 ms atomic, 1.8 ms split; 11 reserved
// - Arm bit self-clears after four cycles
// - Select locked while busy; resets to 00 only when idle
// - Ready interrupt level while idle and enabled
module nv_access_ctrl
  import nv_access_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 prog_tick_i,
  input  wire logic                 gie_i,
  input  wire logic                 ptr_we_i,
  input  wire logic [NV_ADDR_W-1:0] ptr_wdata_i,
  input  wire logic                 val_we_i,
  input  wire logic [7:0]           val_wdata_i,
  input  wire logic                 sel_we_i,
  input  wire logic [1:0]           sel_wdata_i,
  input  wire logic                 irq_en_we_i,
  input  wire logic                 irq_en_wdata_i,
  input  wire logic                 arm_set_i,
  input  wire logic                 prog_set_i,
  input  wire logic                 read_set_i,
  output logic      [NV_ADDR_W-1:0] nv_byte_pointer_o,
  output logic      [7:0]           nv_byte_value_o,
  output logic      [1:0]           program_action_select_o,
  output logic                      ready_irq_enable_o,
  output logic                      program_arm_o,
  output logic                      program_strobe_o,
  output logic                      stall_o,
  output logic                      ready_irq_o
);
  // ****************************************************************
  // Tick synchroniser
  // ****************************************************************
  logic tick_s1_q, tick_s2_q, tick_s3_q, tick_pulse;
  always_ff @(posedge clk_i) begin
    tick_s1_q <= prog_tick_i;
    tick_s2_q <= tick_s1_q;
    tick_s3_q <= tick_s2_q;
  end
  assign tick_pulse = tick_s2_q & ~tick_s3_q;

  // ****************************************************************
  // Control state
  // ****************************************************************
  prog_state_type         state_q;
  logic [TICK_CNT_W-1:0]  ticks_q;
  logic [2:0]             arm_cnt_q;
  logic [2:0]             stall_cnt_q;
  logic                   busy, start, do_read, phase_done, atomic_q;
  logic [7:0]             rdata;
  logic                   rd_pending_q;

  function automatic logic [TICK_CNT_W-1:0] phase_ticks(input logic [1:0] sel);
    phase_ticks = (sel == ACT_ATOMIC) ? TICK_CNT_W'(ATOMIC_TICKS / 2)
                                      : TICK_CNT_W'(SPLIT_TICKS);
  endfunction

  assign busy       = (state_q != ST_IDLE);
  // Reserved select is refused so software cannot start an undefined action
  assign start      = prog_set_i & program_arm_o & ~busy &
                      (program_action_select_o != ACT_RESERVED);
  assign do_read    = read_set_i & ~busy;
  assign phase_done = busy & tick_pulse & (ticks_q == TICK_CNT_W'(1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= ST_IDLE;
      ticks_q  <= '0;
      atomic_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            atomic_q <= (program_action_select_o == ACT_ATOMIC);
            ticks_q  <= phase_ticks(program_action_select_o);
            state_q  <= (program_action_select_o == ACT_WRITE) ? ST_WRITE
                                                                 : ST_ERASE;
          end
        end
        ST_ERASE: begin
          if (phase_done) begin
            if (atomic_q) begin
              ticks_q <= phase_ticks(ACT_ATOMIC);
              state_q <= ST_WRITE;
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (tick_pulse) begin
            ticks_q <= ticks_q - TICK_CNT_W'(1);
          end
        end
        ST_WRITE: begin
          if (phase_done) begin
            state_q <= ST_IDLE;
          end else if (tick_pulse) begin
            ticks_q <= ticks_q - TICK_CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Array work happens at the end of each phase so an aborted time never corrupts
  nv_byte_array u_array (
    .clk_i   (clk_i),
    .addr_i  (nv_byte_pointer_o),
    .rd_i    (do_read),
    .erase_i (phase_done & (state_q == ST_ERASE)),
    .write_i (phase_done & (state_q == ST_WRITE)),
    .wdata_i (nv_byte_value_o),
    .rdata_o (rdata)
  );

  // Strobe mirrors the busy state, so it drops only when work is finished
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_strobe_o <= 1'b0;
    end else begin
      program_strobe_o <= (busy & ~(phase_done & ~(atomic_q & state_q == ST_ERASE)))
                          | start;
    end
  end

  // ****************************************************************
  // Arm window
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_arm_o <= 1'b0;
      arm_cnt_q     <= '0;
    end else if (arm_set_i) begin
      program_arm_o <= 1'b1;
      arm_cnt_q     <= ARM_WINDOW_CYC;
    end else if (program_arm_o) begin
      arm_cnt_q     <= arm_cnt_q - 3'h1;
      program_arm_o <= (arm_cnt_q != 3'h1) & ~start;
    end
  end

  // ****************************************************************
  // Processor stall
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stall_cnt_q <= '0;
      stall_o     <= 1'b0;
    end else if (do_read | start) begin
      stall_cnt_q <= do_read ? READ_STALL_CYC - 3'h1
                             : PROG_STALL_CYC - 3'h1;
      stall_o     <= 1'b1;
    end else if (stall_cnt_q != '0) begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
    end else begin
      stall_o     <= 1'b0;
    end
  end

  // ****************************************************************
  // Pointer, value, select, enable
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_byte_pointer_o <= '0;
    end else if (ptr_we_i & ~busy) begin
      nv_byte_pointer_o <= ptr_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pending_q <= 1'b0;
    end else begin
      rd_pending_q <= do_read;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_byte_value_o <= VALUE_RESET;
    end else if (rd_pending_q) begin
      nv_byte_value_o <= rdata;
    end else if (val_we_i & ~busy) begin
      nv_byte_value_o <= val_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i & ~busy) begin
      program_action_select_o <= ACT_ATOMIC;
    end else if (sel_we_i & ~program_strobe_o & ~rst_i) begin
      program_action_select_o <= sel_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_irq_enable_o <= 1'b0;
      ready_irq_o        <= 1'b0;
    end else begin
      if (irq_en_we_i) begin
        ready_irq_enable_o <= irq_en_wdata_i;
      end
      ready_irq_o <= ready_irq_enable_o & gie_i & ~busy & ~start;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_read_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    do_read |=> stall_o [*4] ##1 !stall_o) else $error("read stall not four cycles");
  a_prog_stall: assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> stall_o [*2] ##1 !stall_o) else $error("program stall not two cycles");
  a_start_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> program_strobe_o) else $error("strobe not set on start");
  a_strobe_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    busy |-> ##1 (program_strobe_o || $past(phase_done))) else $error("strobe dropped early");
  a_busy_noread: assert property (@(posedge clk_i) disable iff (rst_i)
    busy && read_set_i |=> ##1 $stable(nv_byte_value_o) || $past(val_we_i))
    else $error("read acted while busy");
  a_arm_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    arm_set_i ##1 !arm_set_i [*4] |=> !program_arm_o) else $error("arm not cleared");
  a_select_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    program_strobe_o && $past(program_strobe_o) |-> $stable(program_action_select_o))
    else $error("select changed while busy");
  a_ready_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    busy |=> !ready_irq_o) else $error("ready interrupt while busy");
  a_erase_only: assert property (@(posedge clk_i) disable iff (rst_i)
    start && program_action_select_o == ACT_ERASE |=> state_q == ST_ERASE && !atomic_q)
    else $error("erase-only not entered");

  c_read:   cover property (@(posedge clk_i) do_read);
  c_atomic: cover property (@(posedge clk_i) start && program_action_select_o == ACT_ATOMIC);
  c_write:  cover property (@(posedge clk_i) start && program_action_select_o == ACT_WRITE);
  c_done:   cover property (@(posedge clk_i) phase_done && state_q == ST_WRITE);
endmodule : nv_access_ctrl

// File: verification/tb.sv
// Self-checking bench for the byte storage controller, driven port by port.
// Assumes the package constants and one 100 MHz clock; ticks come from the bench.
`timescale 1ns/1ps
module tb;
  import nv_access_pkg::*;
  logic                 clk_i, rst_i, prog_tick_i, gie_i, ptr_we_i, val_we_i, sel_we_i;
  logic                 irq_en_we_i, irq_en_wdata_i, arm_set_i, prog_set_i, read_set_i;
  logic [NV_ADDR_W-1:0] ptr_wdata_i, nv_byte_pointer_o;
  logic [7:0]           val_wdata_i, nv_byte_value_o;
  logic [1:0]           sel_wdata_i, program_action_select_o;
  logic                 ready_irq_enable_o, program_arm_o, program_strobe_o, stall_o, ready_irq_o;
  int                   mismatches, num_checks;

  nv_access_ctrl uut (
    .clk_i(clk_i), .rst_i(rst_i), .prog_tick_i(prog_tick_i), .gie_i(gie_i),
    .ptr_we_i(ptr_we_i), .ptr_wdata_i(ptr_wdata_i), .val_we_i(val_we_i),
    .val_wdata_i(val_wdata_i), .sel_we_i(sel_we_i), .sel_wdata_i(sel_wdata_i),
    .irq_en_we_i(irq_en_we_i), .irq_en_wdata_i(irq_en_wdata_i), .arm_set_i(arm_set_i),
    .prog_set_i(prog_set_i), .read_set_i(read_set_i), .nv_byte_pointer_o(nv_byte_pointer_o),
    .nv_byte_value_o(nv_byte_value_o), .program_action_select_o(program_action_select_o),
    .ready_irq_enable_o(ready_irq_enable_o), .program_arm_o(program_arm_o),
    .program_strobe_o(program_strobe_o), .stall_o(stall_o), .ready_irq_o(ready_irq_o)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Inputs move 1 ns after the edge so sampling never races the drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic load(input logic [1:0] sel, input logic [8:0] ptr, input logic [7:0] val);
    sel_we_i    = 1'b1;
    sel_wdata_i = sel;
    ptr_we_i    = 1'b1;
    ptr_wdata_i = ptr;
    val_we_i    = 1'b1;
    val_wdata_i = val;
    cyc(1);
    sel_we_i = 1'b0;
    ptr_we_i = 1'b0;
    val_we_i = 1'b0;
  endtask : load

  // Gap is the distance in cycles from the arm pulse to the strobe pulse
  task automatic start(input int gap);
    arm_set_i = 1'b1;
    cyc(1);
    arm_set_i = 1'b0;
    if (gap > 1) cyc(gap - 1);
    // Strobe follows the arm pulse after gap cycles; a gap of 1 puts them back to back
    prog_set_i = 1'b1;
    cyc(1);
    prog_set_i = 1'b0;
  endtask : start

  task automatic stall_seq(input int n, input string msg);
    for (int i = 0; i < n; i++) begin
      chk(stall_o === 1'b1, msg);
      cyc(1);
    end
    chk(stall_o === 1'b0, msg);
  endtask : stall_seq

  // Bounded tick supply; the sync stage may let one extra tick through
  task automatic finish_prog(input int n);
    int k;
    k = 0;
    while (program_strobe_o === 1'b1 && k < n + 2) begin
      prog_tick_i = 1'b1;
      cyc(2);
      prog_tick_i = 1'b0;
      cyc(2);
      k++;
    end
    chk(k >= n && k <= n + 1 && program_strobe_o === 1'b0, "program time");
    // A strobe that never drops would hang every later scenario
    if (program_strobe_o !== 1'b0) close_out();
  endtask : finish_prog

  task automatic read_chk(input logic [8:0] ptr, input logic [7:0] exp);
    ptr_we_i    = 1'b1;
    ptr_wdata_i = ptr;
    cyc(1);
    ptr_we_i   = 1'b0;
    read_set_i = 1'b1;
    cyc(1);
    read_set_i = 1'b0;
    stall_seq(4, "read stall");
    chk(nv_byte_value_o === exp, "read data");
  endtask : read_chk

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(nv_byte_pointer_o === 9'h000 && nv_byte_value_o === VALUE_RESET, "reset regs");
    chk(program_action_select_o === ACT_ATOMIC, "reset select");
    chk({program_arm_o, program_strobe_o, stall_o, ready_irq_o} === 4'h0, "reset flags");
    $display("test reset done");
  endtask : t_reset

  task automatic t_arm;
    prog_set_i = 1'b1;
    cyc(1);
    prog_set_i = 1'b0;
    chk(program_strobe_o === 1'b0, "strobe without arm");
    arm_set_i = 1'b1;
    cyc(1);
    arm_set_i = 1'b0;
    chk(program_arm_o === 1'b1, "arm set");
    cyc(4);
    chk(program_arm_o === 1'b0, "arm self clear");
    start(5);
    chk(program_strobe_o === 1'b0, "late strobe");
    $display("test arm done");
  endtask : t_arm

  task automatic t_irq;
    irq_en_we_i    = 1'b1;
    irq_en_wdata_i = 1'b1;
    gie_i          = 1'b1;
    cyc(1);
    irq_en_we_i = 1'b0;
    cyc(1);
    chk(ready_irq_enable_o === 1'b1 && ready_irq_o === 1'b1, "irq idle");
    gie_i = 1'b0;
    cyc(2);
    chk(ready_irq_o === 1'b0, "irq masked");
    gie_i = 1'b1;
    $display("test irq done");
  endtask : t_irq

  task automatic t_atomic;
    load(ACT_ATOMIC, 9'h1a5, 8'h3c);
    start(1);
    chk(program_strobe_o === 1'b1, "atomic start");
    stall_seq(2, "program stall");
    read_set_i  = 1'b1;
    load(ACT_ERASE, 9'h002, 8'hc3);
    read_set_i  = 1'b0;
    chk(stall_o === 1'b0 && nv_byte_value_o === 8'h3c, "busy read");
    chk(nv_byte_pointer_o === 9'h1a5, "busy pointer");
    chk(program_action_select_o === ACT_ATOMIC, "busy select");
    chk(program_strobe_o === 1'b1 && ready_irq_o === 1'b0, "busy flags");
    finish_prog(ATOMIC_TICKS);
    read_chk(9'h1a5, 8'h3c);
    $display("test atomic done");
  endtask : t_atomic

  task automatic t_split;
    load(ACT_ERASE, 9'h1ff, 8'h00);
    start(3);
    chk(program_strobe_o === 1'b1, "erase start");
    finish_prog(SPLIT_TICKS);
    read_chk(9'h1ff, ERASED_VALUE);
    load(ACT_WRITE, 9'h1ff, 8'h5a);
    start(1);
    chk(program_strobe_o === 1'b1, "write start");
    finish_prog(SPLIT_TICKS);
    read_chk(9'h1ff, 8'h5a);
    $display("test split done");
  endtask : t_split

  task automatic t_reserved;
    load(ACT_RESERVED, 9'h000, 8'h11);
    chk(program_action_select_o === ACT_RESERVED, "select load");
    start(1);
    chk(program_strobe_o === 1'b0, "reserved refused");
    load(ACT_ERASE, 9'h010, 8'h00);
    start(1);
    // One reset edge only: a second edge would find the machine idle again
    rst_i = 1'b1;
    cyc(1);
    rst_i = 1'b0;
    chk(program_action_select_o === ACT_ERASE, "select kept busy");
    chk(program_strobe_o === 1'b0, "reset idle");
    $display("test reserved done");
  endtask : t_reserved

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, prog_tick_i, gie_i, ptr_we_i, val_we_i, sel_we_i} = 6'h20;
    {irq_en_we_i, irq_en_wdata_i, arm_set_i, prog_set_i, read_set_i} = 5'h00;
    {ptr_wdata_i, val_wdata_i, sel_wdata_i} = 19'h00000;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    cyc(1);
    t_reset();
    t_arm();
    t_irq();
    t_atomic();
    t_split();
    t_reserved();
    close_out();
  end
endmodule : tb
